//--- asri_core.sv
// serial register access logic with register bank and calibration
//
// Operation
// - reset restores defaults, then self-calibration
// - instruction, result, control, two correction registers
// - result holds latest corrected conversion; one arriving in the same cycle as a host result or correction write is lost
// - offset from calibration or host, last wins; gain from host only
// - instruction byte first, never read back
// - four registers readable and writable by host
// - instruction: direction, count, zero, address
// - direction 0 writes, 1 reads
// - count field gives one to four bytes
// - address steps upward for writes, and for reads while the byte order bit is clear
// - byte order bit steps reads downward
// - transfer runs exactly the instructed bytes
// - byte address map of four registers
// - transfer done, next byte is instruction
// - control byte applies at its last bit
// - control word field layout and defaults
// - sync strobe written, inverted ready flag read
// - bias enable defaults off
// - reference enable defaults on
// - format bit selects two's or offset binary
// - format flips result msb only
`timescale 1ns/10ps
module asri_core #(
  parameter int CAL_LEN = asri_pkg::CAL_CYCLES
) (
  // system side
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [23:0] raw_sample,
  input  wire logic        raw_valid,
  // serial link, clocked by host
  input  wire logic        sclk,
  input  wire logic        frame_b,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_b,
  // analog and status controls
  output logic             bias_enable,
  output logic             reference_drive_enable,
  output logic             sync_pulse,
  output logic             result_ready_flag,
  output logic             cal_busy
);
  typedef enum logic [1:0] {
    ST_INSTR = 2'b00, ST_DATA = 2'b01
  } asri_state_t;

  // link domain state
  asri_state_t state_reg;               // instruction or data phase
  logic [3:0]  bitcnt_reg;              // bit within byte
  logic [7:0]  shift_reg;               // incoming bits
  logic [7:0]  out_reg;                 // outgoing byte
  logic        dir_reg;                 // 1 = read
  logic [2:0]  left_reg;                // bytes still to move
  logic [3:0]  addr_reg;                // current byte address
  logic [31:0] ctl_reg;                 // control word
  logic        wr_tog_reg;              // toggles per host byte write
  logic [3:0]  wr_addr_reg;             // address of that write
  logic [7:0]  wr_data_reg;             // data of that write
  logic        sync_tog_reg;            // toggles on sync strobe
  logic [2:0]  rdy_sync_reg;            // ready level into link
  logic        sdo_reg;
  logic        sdo_oe_b_reg;

  // system domain state
  logic [23:0] result_reg;
  logic [23:0] ofs_reg;
  logic [23:0] gan_reg;
  logic [31:0] cal_cnt_reg;
  logic        cal_reg;
  logic [2:0]  wsync_reg;               // write toggle synchroniser
  logic [2:0]  ssync_reg;               // sync toggle synchroniser
  logic        rdy_reg;
  logic        sync_p_reg;

  // frame qualifier; the link clock runs inside frames, and outside them only while reset is held
  wire frame_on = ~frame_b;
  wire [7:0] in_byte = {shift_reg[6:0], sdi};
  wire byte_end = (bitcnt_reg == asri_pkg::BIT_LAST);
  wire byte_order = ctl_reg[asri_pkg::CTL_ORDER];
  // next address: reads go down when byte order set
  wire [3:0] addr_step = (dir_reg && byte_order) ?
      addr_reg - 4'h1 : addr_reg + 4'h1;

  // read mux; result and correction words are read straight across
  // domains with no synchroniser, so a stale byte may be returned
  wire [7:0] rd_res = (addr_reg == 4'h0) ? result_reg[23:16] :
                      (addr_reg == 4'h1) ? result_reg[15:8] :
                                           result_reg[7:0];
  wire [7:0] rd_cal_src [0:1];
  assign rd_cal_src[0] = (addr_reg[1:0] == 2'h0) ? ofs_reg[23:16] :
                         (addr_reg[1:0] == 2'h1) ? ofs_reg[15:8] :
                                                   ofs_reg[7:0];
  assign rd_cal_src[1] = (addr_reg[1:0] == 2'h0) ? gan_reg[23:16] :
                         (addr_reg[1:0] == 2'h1) ? gan_reg[15:8] :
                                                   gan_reg[7:0];
  // control byte 3 reads the inverted ready flag in its low bit
  wire [7:0] ctl_b3 = {ctl_reg[31:25], ~rdy_sync_reg[2]};
  wire [7:0] rd_ctl = (addr_reg[1:0] == 2'h0) ? ctl_b3 :
                      (addr_reg[1:0] == 2'h1) ? ctl_reg[23:16] :
                      (addr_reg[1:0] == 2'h2) ? ctl_reg[15:8] :
                                                ctl_reg[7:0];
  wire mapped = (addr_reg[1:0] != 2'h3) || (addr_reg[3:2] == 2'h1);
  wire [7:0] rd_byte = !mapped ? 8'h00 :
      (addr_reg[3:2] == 2'h0) ? rd_res :
      (addr_reg[3:2] == 2'h1) ? rd_ctl :
      rd_cal_src[addr_reg[3]  & addr_reg[2]];

  // link-side sequencer: instruction then n data bytes
  always_ff @(posedge sclk) begin
    if (!rst_b || !frame_on) begin
      bitcnt_reg <= 4'h0;
      state_reg  <= ST_INSTR;
    end else begin
      shift_reg  <= in_byte;
      bitcnt_reg <= byte_end ? 4'h0 : bitcnt_reg + 4'h1;
      if (byte_end && state_reg == ST_INSTR) begin
        // instruction byte is never returned
        dir_reg   <= in_byte[asri_pkg::INS_DIR_BIT];
        left_reg  <= {1'b0, in_byte[asri_pkg::INS_CNT_HI:
                     asri_pkg::INS_CNT_LO]} + asri_pkg::CNT_ONE;
        addr_reg  <= in_byte[3:0];
        state_reg <= ST_DATA;
      end else if (byte_end) begin
        addr_reg  <= addr_step;
        left_reg  <= left_reg - asri_pkg::CNT_ONE;
        if (left_reg == asri_pkg::CNT_ONE)
          state_reg <= ST_INSTR;
      end
    end
  end

  // read data shifts out on the falling edge
  always_ff @(negedge sclk) begin
    if (!rst_b) begin
      sdo_reg      <= 1'b0;
      sdo_oe_b_reg <= 1'b1;
      out_reg      <= 8'h00;
    end else if (state_reg == ST_DATA && dir_reg && frame_on) begin
      // load at byte start, else shift msb first
      out_reg      <= (bitcnt_reg == 4'h0) ? {rd_byte[6:0], 1'b0}
                                          : {out_reg[6:0], 1'b0};
      sdo_reg      <= (bitcnt_reg == 4'h0) ? rd_byte[7] : out_reg[7];
      sdo_oe_b_reg <= 1'b0;
    end else begin
      sdo_oe_b_reg <= 1'b1;
    end
  end

  // writes commit at the falling edge of each byte's last bit
  // the pending flag bridges the rising-edge sampler and the
  // falling-edge commit, so a byte never lands half a bit late
  logic       pend_reg;                   // a byte waits to commit
  logic [7:0] pend_data_reg;
  logic [3:0] pend_addr_reg;
  always_ff @(posedge sclk) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg      <= frame_on && byte_end && state_reg == ST_DATA
                       && !dir_reg;
      pend_data_reg <= in_byte;
      pend_addr_reg <= addr_reg;
    end
  end

  // control word lives in the link domain so it applies per byte
  always_ff @(negedge sclk) begin
    if (!rst_b) begin
      ctl_reg      <= asri_pkg::CTL_RESET;
      wr_tog_reg   <= 1'b0;
      sync_tog_reg <= 1'b0;
      wr_addr_reg  <= 4'h0;
      wr_data_reg  <= 8'h00;
    end else if (pend_reg) begin
      wr_addr_reg <= pend_addr_reg;
      wr_data_reg <= pend_data_reg;
      wr_tog_reg  <= ~wr_tog_reg;
      if (pend_addr_reg == asri_pkg::ADDR_CTL_HI) begin
        ctl_reg[31:25] <= pend_data_reg[7:1];
        if (pend_data_reg[0])
          sync_tog_reg <= ~sync_tog_reg;
      end
      if (pend_addr_reg == 4'h5)
        ctl_reg[23:16] <= pend_data_reg;
      if (pend_addr_reg == 4'h6)
        ctl_reg[15:8] <= pend_data_reg;
      if (pend_addr_reg == asri_pkg::ADDR_CTL_LO)
        ctl_reg[7:0] <= pend_data_reg;
    end
  end

  // ready level into the link domain
  always_ff @(posedge sclk) begin
    rdy_sync_reg <= {rdy_sync_reg[1:0], rdy_reg};
  end

  // system side: synchronise write and sync toggles
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wsync_reg <= 3'h0;
      ssync_reg <= 3'h0;
    end else begin
      wsync_reg <= {wsync_reg[1:0], wr_tog_reg};
      ssync_reg <= {ssync_reg[1:0], sync_tog_reg};
    end
  end
  wire host_wr = wsync_reg[2] ^ wsync_reg[1];

  // control levels cross into the system domain through two flops
  // each; a level may lag the host by a few clk cycles, harmless
  // for bias, reference and format which change rarely
  logic [2:0] lvl_a_reg;                  // bias, reference, format
  logic [2:0] lvl_b_reg;                  // settled copy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvl_a_reg <= {asri_pkg::CTL_RESET[asri_pkg::CTL_BIAS],
                    asri_pkg::CTL_RESET[asri_pkg::CTL_REFERENCE_DRIVE_ENABLE],
                    asri_pkg::CTL_RESET[asri_pkg::CTL_FMT]};
      lvl_b_reg <= {asri_pkg::CTL_RESET[asri_pkg::CTL_BIAS],
                    asri_pkg::CTL_RESET[asri_pkg::CTL_REFERENCE_DRIVE_ENABLE],
                    asri_pkg::CTL_RESET[asri_pkg::CTL_FMT]};
    end else begin
      lvl_a_reg <= {ctl_reg[asri_pkg::CTL_BIAS],
                    ctl_reg[asri_pkg::CTL_REFERENCE_DRIVE_ENABLE],
                    ctl_reg[asri_pkg::CTL_FMT]};
      lvl_b_reg <= lvl_a_reg;
    end
  end
  wire fmt = lvl_b_reg[0];                // synchronised format level

  // correction: offset removed, gain applied with product bits 46 to 23 kept, 80_0000 is unity
  wire [47:0] prod = ($signed({{24{1'b0}}, raw_sample}) -
                      $signed({{24{ofs_reg[23]}}, ofs_reg})) *
                     {24'h000000, gan_reg};
  wire [23:0] corr = prod[46:23];

  // system side: calibration, corrections and result
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ofs_reg     <= asri_pkg::OFS_RESET;
      gan_reg     <= asri_pkg::GAN_RESET;
      result_reg  <= 24'h000000;
      cal_reg     <= 1'b1;
      cal_cnt_reg <= 32'h0;
      rdy_reg     <= 1'b0;
      sync_p_reg  <= 1'b0;
    end else begin
      sync_p_reg <= ssync_reg[2] ^ ssync_reg[1];
      if (cal_reg) begin
        cal_cnt_reg <= cal_cnt_reg + 32'h1;
        if (cal_cnt_reg == 32'(CAL_LEN - 1)) begin
          cal_reg <= 1'b0;
          ofs_reg <= asri_pkg::OFS_RESET;
        end
      end
      // byte 3 of a correction word does not exist: drop it
      if (host_wr && wr_addr_reg[3] &&
          wr_addr_reg[1:0] != 2'h3) begin
        if (wr_addr_reg[2])
          gan_reg[8*(2-wr_addr_reg[1:0]) +: 8] <= wr_data_reg;
        else
          ofs_reg[8*(2-wr_addr_reg[1:0]) +: 8] <= wr_data_reg;
      end else if (host_wr && wr_addr_reg[3:2] == 2'h0 &&
                   wr_addr_reg[1:0] != 2'h3) begin
        result_reg[8*(2-wr_addr_reg[1:0]) +: 8] <= wr_data_reg;
      end else if (raw_valid && !cal_reg) begin
        result_reg <= {corr[23] ^ fmt, corr[22:0]};
        rdy_reg    <= 1'b1;
      end
    end
  end

  // outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bias_enable            <= 1'b0;
      reference_drive_enable <= 1'b1;
      sync_pulse             <= 1'b0;
      result_ready_flag      <= 1'b0;
      cal_busy               <= 1'b1;
    end else begin
      bias_enable            <= lvl_b_reg[2];
      reference_drive_enable <= lvl_b_reg[1];
      sync_pulse             <= sync_p_reg;
      result_ready_flag      <= rdy_reg;
      cal_busy               <= cal_reg;
    end
  end
  assign sdo      = sdo_reg;
  assign sdo_oe_b = sdo_oe_b_reg;

  // checks
  property p_cal_ends;
    @(posedge clk) disable iff (!rst_b)
      cal_reg && cal_cnt_reg == 32'(CAL_LEN - 1) |=> !cal_reg;
  endproperty
  a_cal_ends: assert property (p_cal_ends)
    else $error("calibration did not end");
  property p_fmt;
    @(posedge clk) disable iff (!rst_b)
      raw_valid && !cal_reg && !host_wr |=>
        result_reg[23] == ($past(corr[23]) ^ $past(fmt));
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("format msb wrong");
  // the output stays released while an instruction comes in
  property p_oe;
    @(posedge sclk) disable iff (!rst_b)
      frame_on && state_reg == ST_INSTR |-> sdo_oe_b_reg;
  endproperty
  a_oe: assert property (p_oe)
    else $error("output driven during instruction");
  // byte count loaded from the instruction field
  property p_count;
    @(posedge sclk) disable iff (!rst_b)
      frame_on && byte_end && state_reg == ST_INSTR |=>
        left_reg == 3'($past(in_byte[asri_pkg::INS_CNT_HI:
                                     asri_pkg::INS_CNT_LO]) + 1);
  endproperty
  a_count: assert property (p_count)
    else $error("byte count not loaded");
  // address moves by one per data byte
  property p_step;
    @(posedge sclk) disable iff (!rst_b)
      frame_on && byte_end && state_reg == ST_DATA &&
      left_reg != asri_pkg::CNT_ONE |=>
        addr_reg == ($past(dir_reg && byte_order) ?
                     $past(addr_reg) - 4'h1 : $past(addr_reg) + 4'h1);
  endproperty
  a_step: assert property (p_step)
    else $error("address step wrong");
  // unmapped reads shift out a zero first (msb) bit
  property p_unmapped;
    @(negedge sclk) disable iff (!rst_b)
      frame_on && state_reg == ST_DATA && dir_reg &&
      bitcnt_reg == 4'h0 && !mapped |=> !sdo_reg;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  // control byte 3 lands at the falling edge of its last bit
  property p_ctl_commit;
    @(negedge sclk) disable iff (!rst_b)
      pend_reg && pend_addr_reg == asri_pkg::ADDR_CTL_HI |=>
        ctl_reg[31:25] == $past(pend_data_reg[7:1]);
  endproperty
  a_ctl_commit: assert property (p_ctl_commit)
    else $error("control byte not committed");
endmodule : asri_core

//--- asri_pkg.sv
// package: constants for the serial register interface
package asri_pkg;
  // instruction byte fields
  localparam int INS_DIR_BIT = 7;
  localparam int INS_CNT_HI  = 6;
  localparam int INS_CNT_LO  = 5;
  localparam int INS_ZERO    = 4;
  // byte address map
  localparam logic [3:0] ADDR_RES_HI  = 4'h0;
  localparam logic [3:0] ADDR_RES_LO  = 4'h2;
  localparam logic [3:0] ADDR_CTL_HI  = 4'h4;
  localparam logic [3:0] ADDR_CTL_LO  = 4'h7;
  localparam logic [3:0] ADDR_OFS_HI  = 4'h8;
  localparam logic [3:0] ADDR_OFS_LO  = 4'ha;
  localparam logic [3:0] ADDR_GAN_HI  = 4'hc;
  localparam logic [3:0] ADDR_GAN_LO  = 4'he;
  // control word reset value and fields
  localparam logic [31:0] CTL_RESET   = 32'h4000_0017;
  localparam int CTL_BIAS    = 31;
  localparam int CTL_REFERENCE_DRIVE_ENABLE    = 30;
  localparam int CTL_FMT     = 29;
  localparam int CTL_ORDER   = 27;
  localparam int CTL_SYNC    = 24;
  localparam int CTL_MODE_HI = 23;
  localparam int CTL_MODE_LO = 21;
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_SELFCAL = 3'h1;
  // calibration defaults and run time, then link bit and byte count constants
  localparam logic [23:0] OFS_RESET   = 24'h00_0000;
  localparam logic [23:0] GAN_RESET   = 24'h80_0000;
  localparam int CAL_RATE_HZ = 340;
  localparam int CLK_HZ      = 50000000;
  localparam int CAL_CYCLES  = CLK_HZ / CAL_RATE_HZ;
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [2:0] CNT_ONE     = 3'h1;
endpackage : asri_pkg

//--- asri_host.sv
// host model that clocks the serial link of the register interface
`timescale 1ns/10ps
module asri_host (
  // serial link
  output logic      sclk,
  output logic      frame_b,
  output logic      sdi,
  input  wire logic sdo
);
  // link clock stands still and frame is released when idle
  initial begin
    sclk    = 1'b0;
    frame_b = 1'b1;
    sdi     = 1'b0;
  end
  // one link clock outside any frame, only while reset is held
  task automatic tick();
    #80 sclk = 1'b1;
    #80 sclk = 1'b0;
  endtask : tick
  // one frame: instruction byte, then n bytes, msb first
  task automatic xfer(input logic [7:0] ins, input int n,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] sh;
    #3;
    sh      = {ins, wd << (8 * (4 - n))};
    rd      = 32'h0;
    frame_b = 1'b0;
    for (int i = 0; i < 8 * (n + 1); i++) begin
      sdi = sh[39 - i];
      #80 sclk = 1'b1;
      if (i >= 8) rd = {rd[30:0], sdo};
      #80 sclk = 1'b0;
    end
    // hold the frame past the last falling edge so the commit sees it
    #40 frame_b = 1'b1;
    sdi = ~sdi; // released line must not keep its last value
    #160;
  endtask : xfer
endmodule : asri_host

//--- adc_serial_register_interface_tb_top.sv
// testbench for the serial register interface
`timescale 1ns/10ps
module adc_serial_register_interface_tb_top;
  // system side
  logic        clk;
  logic        rst_b;
  logic [23:0] raw_sample;
  logic        raw_valid;
  // link and device outputs
  logic        sclk, frame_b, sdi, sdo, sdo_oe_b;
  logic        bias_enable, reference_drive_enable, sync_pulse;
  logic        result_ready_flag, cal_busy;
  // sync pulse is one clk long, so it is caught in a sticky flag
  logic        sync_seen;
  int          num_errors;
  int          check_count;
  // short calibration keeps the run brief
  asri_core #(.CAL_LEN(20)) u_asri_core (
    .clk(clk), .rst_b(rst_b), .raw_sample(raw_sample),
    .raw_valid(raw_valid), .sclk(sclk), .frame_b(frame_b), .sdi(sdi),
    .sdo(sdo), .sdo_oe_b(sdo_oe_b), .bias_enable(bias_enable),
    .reference_drive_enable(reference_drive_enable),
    .sync_pulse(sync_pulse), .result_ready_flag(result_ready_flag),
    .cal_busy(cal_busy)
  );
  asri_host u_asri_host (
    .sclk(sclk), .frame_b(frame_b), .sdi(sdi), .sdo(sdo)
  );
  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // catch the one-cycle sync pulse
  always @(posedge clk) begin
    if (sync_pulse === 1'b1) sync_seen <= 1'b1;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // host write of n bytes, then let outputs cross into clk domain
  task automatic wr(input logic [3:0] a, input int n, input logic [31:0] d);
    logic [31:0] unused;
    u_asri_host.xfer({1'b0, 2'(n - 1), 1'b0, a}, n, d, unused);
    repeat (4) @(negedge clk);
  endtask : wr
  // host read of n bytes compared with an expectation
  task automatic rd(input logic [3:0] a, input int n,
                    input logic [31:0] e, input string nm);
    logic [31:0] d;
    u_asri_host.xfer({1'b1, 2'(n - 1), 1'b0, a}, n, 32'h0, d);
    chk(nm, e, d);
  endtask : rd
  // one raw conversion, then time for correction to land
  task automatic sample(input logic [23:0] s);
    raw_sample = s;
    raw_valid  = 1'b1;
    @(negedge clk);
    raw_valid  = 1'b0;
    repeat (40) @(negedge clk);
  endtask : sample
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // hang guard
  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    rst_b      = 1'b0;
    raw_sample = 24'h0;
    raw_valid  = 1'b0;
    sync_seen  = 1'b0;
    num_errors = 0;
    check_count = 0;
    // two link clocks inside the reset window
    u_asri_host.tick();
    u_asri_host.tick();
    @(negedge clk);
    chk("reset outputs", 32'h7, {28'h0, bias_enable,
        reference_drive_enable, cal_busy, sdo_oe_b});
    rst_b = 1'b1;
    for (int i = 0; i < 200 && cal_busy !== 1'b0; i++) @(negedge clk);
    chk("cal_busy", 32'h0, {31'h0, cal_busy});
    // unity corrections written after calibration win
    wr(4'h8, 3, 32'h0);
    wr(4'hc, 3, 32'h80_0000);
    sample(24'h12_3456);
    chk("ready", 32'h1, {31'h0, result_ready_flag});
    rd(4'h0, 3, 32'h12_3456, "result");
    for (int n = 1; n <= 4; n++) begin
      rd(4'h4, n, asri_pkg::CTL_RESET >> (8 * (4 - n)), "control");
    end
    // offset binary with reference off
    wr(4'h4, 1, 32'h20);
    chk("ref off", 32'h0, {31'h0, reference_drive_enable});
    sample(24'h12_3456);
    rd(4'h0, 3, 32'h92_3456, "offset binary");
    rd(4'hc, 3, 32'h80_0000, "gain kept");
    // offset register and upward stepping
    wr(4'h8, 3, 32'ha5_c33c);
    rd(4'h8, 3, 32'ha5_c33c, "offset");
    rd(4'h9, 2, 32'hc33c, "offset low");
    // bias, reference, byte order down and sync in one byte
    wr(4'h4, 1, 32'hc9);
    chk("bias ref sync", 32'h7, {29'h0, bias_enable,
        reference_drive_enable, sync_seen});
    rd(4'h4, 1, 32'hc8, "ready bit");
    rd(4'ha, 2, 32'h3cc3, "down read");
    wr(4'hc, 2, 32'h1122);
    rd(4'he, 3, 32'h00_2211, "up write");
    // unmapped places
    wr(4'hf, 1, 32'hff);
    rd(4'h3, 1, 32'h0, "unmapped low");
    rd(4'hf, 1, 32'h0, "unmapped high");
    rd(4'hc, 1, 32'h11, "gain after unmapped");
    wrap_up();
  end
endmodule : adc_serial_register_interface_tb_top
